// [design/sal_pkg.sv]
// Purpose: shared constants and types for the socket activity indicator block
// Assumes: 250 MHz system clock; socket status comes from logic on the same clock
// Notes: hold time counted in clock cycles from the one system clock
//
// Notes on behaviour
// - indicators can leave on multifunction terminals
// - terminal driven high signals socket activity
// - separate indicators for socket A and B
// - combined indicator for either socket
// - each activity holds indicator high 64 ms
// - idle indicator actively driven low
// - activity counts only inserted, powered, unreset card
// - 16-bit card: low ready line is activity
// - CardBus: frame, ready or request is activity
// - suspend, clock stop, D1/D2 force indicators off
// - new activity restarts running hold counter
package sal_pkg;

	// =========================================================
	// timing
	localparam int unsigned HOLD_MS = 64;
	localparam int unsigned CLOCK_KHZ = 250000;
	localparam int unsigned HOLD_CYCLES = HOLD_MS * CLOCK_KHZ;
	localparam int unsigned CNT_WIDTH = 24;

	// =========================================================
	// terminal routing selections
	localparam logic [1:0] MF_SEL_OFF = 2'h0;
	localparam logic [1:0] MF_SEL_A = 2'h1;
	localparam logic [1:0] MF_SEL_B = 2'h2;
	localparam logic [1:0] MF_SEL_ANY = 2'h3;
	localparam int unsigned MF_COUNT = 2;

	// =========================================================
	// types
	typedef enum logic [1:0] {
		SAL_PWR_D0,
		SAL_PWR_D1,
		SAL_PWR_D2,
		SAL_PWR_D3
	} sal_pwr_type;

	typedef struct packed {
		logic inserted;
		logic powered;
		logic inReset;
		logic isCardBus;
		logic readyIreqLow;
		logic frameActive;
		logic irdyActive;
		logic reqActive;
	} sal_socket_type;

	typedef struct packed {
		logic suspend;
		logic clockStopPending;
		sal_pwr_type powerState;
	} sal_power_type;

endpackage : sal_pkg

// [design/sal_detect.sv]
`timescale 1ns/1ps
// Purpose: decides whether one socket shows bus activity this cycle
// Assumes: socket status already in the system clock domain
// Notes: combinational; the hold timer registers the result
module sal_detect
(
	// socket status
	input sal_pkg::sal_socket_type socket,
	// result
	output logic activity
);
	import sal_pkg::*;

	logic valid;
	logic cardSeen;

	// =========================================================
	// activity qualification
	assign valid = socket.inserted & socket.powered & ~socket.inReset;
	assign cardSeen = socket.isCardBus ?
		(socket.frameActive | socket.irdyActive | socket.reqActive) :
		socket.readyIreqLow;
	assign activity = valid & cardSeen;

endmodule : sal_detect

// [design/sal_hold_timer.sv]
`timescale 1ns/1ps
// Purpose: retriggerable hold timer for one indicator
// Assumes: trigger and kill are same-clock levels
// Notes: output high while the count is running
module sal_hold_timer
#(
	parameter int unsigned HOLD = sal_pkg::HOLD_CYCLES
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// control
	input wire logic trigger,
	input wire logic kill,
	// result
	output logic active
);
	import sal_pkg::*;

	typedef struct packed {
		logic [CNT_WIDTH-1:0] count;
	} sal_timer_state_type;

	localparam logic [CNT_WIDTH-1:0] HOLD_LOAD = CNT_WIDTH'(HOLD);

	sal_timer_state_type state_q;
	sal_timer_state_type state_d;

	// =========================================================
	// next state
	always_comb
	begin
		state_d = state_q;
		if (kill)
			state_d.count = '0;
		else if (trigger)
			state_d.count = HOLD_LOAD;
		else if (state_q.count != '0)
			state_d.count = state_q.count - CNT_WIDTH'(1);
	end

	// =========================================================
	// registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign active = (state_q.count != '0);

endmodule : sal_hold_timer

// [design/sal_top.sv]
`timescale 1ns/1ps
// Purpose: socket activity indicators for two card sockets
// Assumes: all inputs come from logic on the one system clock
// Notes: indicator outputs are registered; each multifunction terminal is released in reset and while its selection is off
module sal_top
#(
	parameter int unsigned HOLD = sal_pkg::HOLD_CYCLES
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// socket status
	input sal_pkg::sal_socket_type socketA,
	input sal_pkg::sal_socket_type socketB,
	// power management
	input sal_pkg::sal_power_type power,
	// multifunction terminal routing
	input wire logic [1:0] mfSel0,
	input wire logic [1:0] mfSel1,
	// indicators
	output logic socket_a_activity_led,
	output logic socket_b_activity_led,
	output logic any_socket_activity_led,
	output logic [1:0] multifunction_terminal,
	output logic [1:0] multifunction_terminal_oe_n
);
	import sal_pkg::*;

	typedef struct packed {
		logic ledA;
		logic ledB;
		logic ledAny;
		logic [1:0] mf;
		logic [1:0] mfOeN;
	} sal_top_state_type;

	sal_top_state_type state_q;
	sal_top_state_type state_d;
	logic actA;
	logic actB;
	logic holdA;
	logic holdB;
	logic kill;
	logic [1:0] sel [MF_COUNT];

	// =========================================================
	// activity detection
	sal_detect u_det_a
	(
		.socket(socketA),
		.activity(actA)
	);

	sal_detect u_det_b
	(
		.socket(socketB),
		.activity(actB)
	);

	// cut off so indicators never look stuck with the bus clock stopped
	assign kill = power.suspend | power.clockStopPending |
		(power.powerState == SAL_PWR_D1) | (power.powerState == SAL_PWR_D2);

	// =========================================================
	// hold timers
	sal_hold_timer #(.HOLD(HOLD)) u_hold_a
	(
		.clock(clock),
		.rst(rst),
		.trigger(actA),
		.kill(kill),
		.active(holdA)
	);

	sal_hold_timer #(.HOLD(HOLD)) u_hold_b
	(
		.clock(clock),
		.rst(rst),
		.trigger(actB),
		.kill(kill),
		.active(holdB)
	);

	assign sel[0] = mfSel0;
	assign sel[1] = mfSel1;

	// =========================================================
	// next state
	always_comb
	begin
		state_d = state_q;
		state_d.ledA = holdA & ~kill;
		state_d.ledB = holdB & ~kill;
		state_d.ledAny = (holdA | holdB) & ~kill;
		for (int i = 0; i < MF_COUNT; i++)
		begin
			case (sel[i])
				MF_SEL_A: state_d.mf[i] = state_d.ledA;
				MF_SEL_B: state_d.mf[i] = state_d.ledB;
				MF_SEL_ANY: state_d.mf[i] = state_d.ledAny;
				default: state_d.mf[i] = 1'b0;
			endcase
			state_d.mfOeN[i] = (sel[i] == MF_SEL_OFF);
		end
	end

	// =========================================================
	// registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			state_q <= '{ledA: 1'b0, ledB: 1'b0, ledAny: 1'b0, mf: 2'h0, mfOeN: 2'h3};
		else
			state_q <= state_d;
	end

	assign socket_a_activity_led = state_q.ledA;
	assign socket_b_activity_led = state_q.ledB;
	assign any_socket_activity_led = state_q.ledAny;
	assign multifunction_terminal = state_q.mf;
	assign multifunction_terminal_oe_n = state_q.mfOeN;

endmodule : sal_top

// [dv/sal_led_board.sv]
`timescale 1ns/1ps
// Purpose: board lamps on the terminals
// Assumes: pulldown on each terminal
// Notes: lamp lit only while driven high
module sal_led_board
(
	// terminals
	input wire logic [1:0] terminal,
	input wire logic [1:0] enableN,
	// lamps
	output logic [1:0] lit
);
	assign lit = terminal & ~enableN;
endmodule : sal_led_board

// [dv/sal_monitor.sv]
`timescale 1ns/1ps
// Purpose: port assertions for sal_top
// Assumes: one clock domain
// Notes: terminal 0 watched
module sal_monitor
(
	// inputs
	input wire logic clock,
	input wire logic rst,
	input sal_pkg::sal_socket_type socketA,
	input sal_pkg::sal_socket_type socketB,
	input sal_pkg::sal_power_type power,
	input wire logic [1:0] mfSel0,
	input wire logic [1:0] mfSel1,
	// outputs
	input wire logic socket_a_activity_led,
	input wire logic socket_b_activity_led,
	input wire logic any_socket_activity_led,
	input wire logic [1:0] multifunction_terminal,
	input wire logic [1:0] multifunction_terminal_oe_n
);
	import sal_pkg::*;
	function automatic logic act(sal_socket_type s);
		return s.inserted & s.powered & ~s.inReset & (s.isCardBus ? s.frameActive | s.irdyActive | s.reqActive : s.readyIreqLow);
	endfunction : act
	wire actA = act(socketA);
	wire actB = act(socketB);
	wire kill = power.suspend | power.clockStopPending | (power.powerState inside {SAL_PWR_D1, SAL_PWR_D2});
	wire a = socket_a_activity_led;
	wire b = socket_b_activity_led;
	wire y = any_socket_activity_led;
	wire oe = multifunction_terminal_oe_n[0];
	wire mf = multifunction_terminal[0];
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ====
	// checks
	a_a_rise: assert property (actA && !kill ##1 !kill |-> ##[0:1] a) else $error("a late");
	a_b_rise: assert property (actB && !kill ##1 !kill |-> ##[0:1] b) else $error("b late");
	a_a_cause: assert property ($rose(a) |-> $past(actA) || $past(actA, 2)) else $error("a cause");
	a_any_or: assert property (y == (a || b)) else $error("any");
	a_kill_off: assert property (kill [*3] |-> !a && !b && !y) else $error("kill");
	a_retrig_keep: assert property (actA && !kill ##1 a && !kill ##1 !kill |-> a ##1 a) else $error("gap");
	a_mf_oe: assert property (!$past(rst) && !$past(rst, 2) |-> oe == ($past(mfSel0) == MF_SEL_OFF))
		else $error("oe");
	a_mf_val: assert property (!$past(rst, 2) && $past(mfSel0) == MF_SEL_A |-> mf == a) else $error("mf");
	c_a: cover property ($rose(a));
	c_b: cover property ($rose(b));
	c_kill: cover property (kill && y);
endmodule : sal_monitor
bind sal_top sal_monitor sal_monitor_inst (.clock, .rst, .socketA, .socketB, .power, .mfSel0, .mfSel1,
	.socket_a_activity_led, .socket_b_activity_led, .any_socket_activity_led, .multifunction_terminal,
	.multifunction_terminal_oe_n);

// [dv/sal_top_tb_top.sv]
`timescale 1ns/1ps
// Purpose: directed tests of sal_top
// Assumes: hold shortened to 20 cycles
// Notes: inputs change on falling edges
module sal_top_tb_top;
	import sal_pkg::*;
	localparam int unsigned H = 20;
	logic clock = 0;
	logic rst = 1;
	sal_socket_type sA = 8'hC0;
	sal_socket_type sB = 8'hC0;
	sal_power_type pw = 4'h0;
	logic [1:0] s0 = MF_SEL_A;
	logic [1:0] s1 = MF_SEL_ANY;
	logic ledA, ledB, ledAny;
	logic [1:0] mf, oeN, lit;
	logic [7:0] cb[3] = '{8'hD4, 8'hD2, 8'hD1};
	logic [7:0] iv[3] = '{8'hE8, 8'h88, 8'h48};
	logic [3:0] kc[4] = '{4'h8, 4'h4, 4'h1, 4'h2};
	int n_errors = 0;
	int comparisons = 0;
	int n;
	always #2 clock = ~clock;
	sal_top #(.HOLD(H)) sal_top_inst (.clock, .rst, .socketA(sA), .socketB(sB), .power(pw), .mfSel0(s0),
		.mfSel1(s1), .socket_a_activity_led(ledA), .socket_b_activity_led(ledB), .any_socket_activity_led(ledAny),
		.multifunction_terminal(mf), .multifunction_terminal_oe_n(oeN));
	sal_led_board sal_led_board_inst (.terminal(mf), .enableN(oeN), .lit);
	// ====
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
		end
	endtask : check
	task automatic pulse(input bit onB, input logic [7:0] v);
		@(negedge clock);
		if (onB)
			sB = v;
		else
			sA = v;
		@(negedge clock);
		sA = 8'hC0;
		sB = 8'hC0;
	endtask : pulse
	task automatic runlen;
		n = 0;
		while (ledA === 1'b1 && n < 99)
		begin
			@(negedge clock);
			n++;
		end
	endtask : runlen
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	// ====
	// scenarios
	task automatic t_card16;
		pulse(0, 8'hC8);
		@(negedge clock);
		check({ledB, ledAny, lit, oeN}, 6'h1C);
		runlen;
		check(n, H);
		check({ledAny, mf}, 0);
		$display("card16 done");
	endtask : t_card16
	task automatic t_cardbus;
		foreach (cb[i])
		begin
			pulse(1, cb[i]);
			@(negedge clock);
			check({ledA, ledB, lit[1]}, 3'h3);
			repeat (H + 2) @(negedge clock);
		end
		$display("cardbus done");
	endtask : t_cardbus
	task automatic t_invalid;
		foreach (iv[i])
		begin
			pulse(0, iv[i]);
			repeat (3) @(negedge clock);
			check(ledAny, 0);
		end
		$display("invalid done");
	endtask : t_invalid
	task automatic t_route;
		s0 = MF_SEL_B;
		s1 = MF_SEL_B;
		pulse(1, 8'hC8);
		@(negedge clock);
		check({ledA, ledB, lit, oeN}, 6'h1C);
		s0 = MF_SEL_OFF;
		repeat (2) @(negedge clock);
		check({oeN, lit}, 4'h6);
		repeat (H) @(negedge clock);
		check({lit, ledB}, 3'h0);
		s0 = MF_SEL_A;
		s1 = MF_SEL_ANY;
		$display("route done");
	endtask : t_route
	task automatic t_reset;
		pulse(0, 8'hC8);
		@(negedge clock);
		rst = 1;
		@(negedge clock);
		check({ledA, ledAny, oeN}, 4'h3);
		rst = 0;
		repeat (2) @(negedge clock);
		check({ledA, ledAny, oeN}, 4'h0);
		$display("reset done");
	endtask : t_reset
	task automatic t_retrig;
		pulse(0, 8'hC8);
		repeat (H - 4) @(negedge clock);
		pulse(0, 8'hC8);
		@(negedge clock);
		runlen;
		check(n, H);
		$display("retrig done");
	endtask : t_retrig
	task automatic t_kill;
		foreach (kc[i])
		begin
			pulse(0, 8'hC8);
			pw = kc[i];
			pulse(0, 8'hC8);
			@(negedge clock);
			check(ledAny, 0);
			pw = 4'h0;
			repeat (3) @(negedge clock);
			check(ledAny, 0);
		end
		pw = 4'h3;
		pulse(0, 8'hC8);
		@(negedge clock);
		check(ledA, 1);
		pw = 4'h0;
		s1 = MF_SEL_OFF;
		repeat (2) @(negedge clock);
		check({oeN[1], lit[1]}, 2'h2);
		$display("kill done");
	endtask : t_kill
	initial
	begin
		repeat (16) @(negedge clock);
		check({ledA, ledB, ledAny, mf, oeN}, 7'h03);
		rst = 0;
		@(negedge clock);
		check({ledA, ledB, ledAny, mf, oeN}, 7'h00);
		t_card16;
		t_cardbus;
		t_invalid;
		t_route;
		t_retrig;
		t_reset;
		t_kill;
		tally_and_finish;
	end
	initial
	begin
		#8000;
		n_errors++;
		tally_and_finish;
	end
endmodule : sal_top_tb_top
